// ### inc/prom_loader_defs.svh
// Constants for the configuration memory readout block
`ifndef PROM_LOADER_DEFS_SVH
`define PROM_LOADER_DEFS_SVH

// APB register byte addresses
`define CTRL_OFFSET 8'h00
`define LOAD_ADDR_OFFSET 8'h04
`define LOAD_DATA_OFFSET 8'h08
`define STATUS_OFFSET 8'h0C

// Control field positions
`define CTRL_START_BIT 0
`define CTRL_REV_LSB 1
`define CTRL_REV_MSB 2
`define CTRL_BYTE_WIDE_BIT 3
`define CTRL_DECOMP_BIT 4
`define CTRL_REV_EN_BIT 5

// Memory shape
`define MEM_DEPTH 256
`define TERMINAL_COUNT 8'hFF
`define BANK_OFFSET_ZERO 6'h00
`define BANK_OFFSET_TOP 6'h3F
`define LAST_BIT 3'h7

// Trigger pulse timing
`define PULSE_MIN_NS 300
`define PULSE_MAX_NS 500
`define CLK_PERIOD_NS 25
`define SYNC_SETTLE 2'h3
`define PULSE_CYCLES ((`PULSE_MIN_NS + `PULSE_MAX_NS) / (2 * `CLK_PERIOD_NS))

`endif

// ### inc/prom_loader_pkg.sv
// Types shared by the configuration memory readout block
package prom_loader_pkg;

  typedef struct packed {
    logic rev_en;
    logic decompress;
    logic byte_wide;
    logic [1:0] rev;
  } ctrl_t;

  typedef struct packed {
    logic [1:0] revision_select_pins;
    logic external_revision_enable;
    logic config_trigger_in;
    logic busy;
    logic oe_reset_n;
    logic ce_n;
    logic config_clock;
  } pins_t;

  typedef enum logic [1:0] {TRIG_IDLE, TRIG_SAMPLE, TRIG_PULSE} trig_state_t;

endpackage

// ### rtl/pin_sync.sv
// Two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule
`default_nettype wire

// ### rtl/prom_loader.sv
// Configuration memory readout: cascade, address counter and trigger pulse
`timescale 1ns/1ps
`default_nettype none
`include "prom_loader_defs.svh"
module prom_loader #(
  parameter bit SERIAL_ONLY = 1'b0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Target configuration port
  input wire logic config_clock,
  input wire logic busy,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic forwarded_clock,
  output logic forwarded_clock_oe,
  // Cascade and reset pins
  input wire logic ce_n,
  input wire logic oe_reset_n,
  output logic chain_enable_out_n,
  // Trigger line, drawn as three signals
  input wire logic config_trigger_in,
  output logic config_trigger_out,
  output logic config_trigger_oe,
  // Revision selection pins
  input wire logic external_revision_enable,
  input wire logic [1:0] revision_select_pins
);

  prom_loader_pkg::pins_t raw_pins;
  prom_loader_pkg::pins_t pins;
  prom_loader_pkg::ctrl_t ctrl;
  prom_loader_pkg::trig_state_t trig_state;
  logic [7:0] mem [`MEM_DEPTH];
  logic [7:0] load_addr;
  logic [7:0] addr;
  logic [2:0] bit_idx;
  logic done;
  logic [1:0] rev_captured;
  logic [4:0] pulse_cnt;
  logic clk_prev;
  logic trig_prev;
  logic start_req;
  logic active;
  logic clk_rise;
  logic trig_rise;
  logic hold;
  logic byte_last;
  logic [1:0] rev_now;
  logic [7:0] bank_start;
  logic [7:0] bank_end;
  logic apb_access;
  logic apb_setup;
  logic [1:0] settle;

  assign raw_pins = '{revision_select_pins: revision_select_pins,
                      external_revision_enable: external_revision_enable,
                      config_trigger_in: config_trigger_in, busy: busy,
                      oe_reset_n: oe_reset_n, ce_n: ce_n, config_clock: config_clock};

  pin_sync #(.WIDTH($bits(prom_loader_pkg::pins_t))) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(raw_pins),
    .sync_out(pins)
  );

  assign active = pins.oe_reset_n && !pins.ce_n;
  assign clk_rise = pins.config_clock && !clk_prev;
  // Synchroniser resets low but the idle line is high: mask that false edge
  assign trig_rise = pins.config_trigger_in && !trig_prev && !SERIAL_ONLY && settle == `SYNC_SETTLE;
  // Busy is ignored in serial or decompressed streams
  assign hold = pins.busy && ctrl.byte_wide && !ctrl.decompress && !SERIAL_ONLY;
  assign byte_last = ctrl.byte_wide || (bit_idx == `LAST_BIT);
  assign rev_now = pins.external_revision_enable ? pins.revision_select_pins : ctrl.rev;
  assign bank_start = ctrl.rev_en ? {rev_captured, `BANK_OFFSET_ZERO} : 8'h00;
  assign bank_end = ctrl.rev_en ? {rev_captured, `BANK_OFFSET_TOP} : `TERMINAL_COUNT;
  assign apb_setup = psel && !penable;
  assign apb_access = psel && penable && pready;

  // Edge history of the synchronised link lines
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_prev <= 1'b0;
      trig_prev <= 1'b0;
    end else begin
      clk_prev <= pins.config_clock;
      trig_prev <= pins.config_trigger_in;
    end
  end

  // Trigger edges count only once the synchroniser holds real pin levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle <= 2'h0;
    end else if (settle != `SYNC_SETTLE) begin
      settle <= settle + 2'h1;
    end
  end

  // APB answers one cycle after setup, so every answer comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= apb_setup;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (apb_setup) begin
        if (paddr == `CTRL_OFFSET) begin
          prdata <= {26'h0, ctrl.rev_en, ctrl.decompress, ctrl.byte_wide, ctrl.rev, start_req};
        end else if (paddr == `LOAD_ADDR_OFFSET) begin
          prdata <= {24'h0, load_addr};
        end else if (paddr == `LOAD_DATA_OFFSET) begin
          prdata <= {24'h0, mem[load_addr]};
        end else if (paddr == `STATUS_OFFSET) begin
          prdata <= {19'h0, !chain_enable_out_n, trig_state != prom_loader_pkg::TRIG_IDLE,
                     done, rev_captured, addr};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // Control register; the start bit stands until the trigger machine takes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= '0;
      start_req <= 1'b0;
    end else begin
      if (trig_state == prom_loader_pkg::TRIG_IDLE) begin
        start_req <= 1'b0;
      end
      if (apb_access && pwrite && paddr == `CTRL_OFFSET) begin
        ctrl.rev <= pwdata[`CTRL_REV_MSB:`CTRL_REV_LSB];
        ctrl.byte_wide <= pwdata[`CTRL_BYTE_WIDE_BIT];
        ctrl.decompress <= pwdata[`CTRL_DECOMP_BIT];
        ctrl.rev_en <= pwdata[`CTRL_REV_EN_BIT];
        if (pwdata[`CTRL_START_BIT] && trig_state == prom_loader_pkg::TRIG_IDLE) begin
          start_req <= 1'b1;
        end
      end
    end
  end

  // Image loading port; the pointer walks so a bitstream streams in byte by byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_addr <= 8'h00;
    end else if (apb_access && pwrite && paddr == `LOAD_ADDR_OFFSET) begin
      load_addr <= pwdata[7:0];
    end else if (apb_access && pwrite && paddr == `LOAD_DATA_OFFSET) begin
      load_addr <= load_addr + 8'h01;
    end
  end

  // Storage has no reset so it maps onto plain RAM
  always_ff @(posedge pclk) begin
    if (apb_access && pwrite && paddr == `LOAD_DATA_OFFSET) begin
      mem[load_addr] <= pwdata[7:0];
    end
  end

  // Trigger machine: sample the revision, then one counted low pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_state <= prom_loader_pkg::TRIG_IDLE;
      pulse_cnt <= 5'h00;
      rev_captured <= 2'h0;
    end else begin
      case (trig_state)
        prom_loader_pkg::TRIG_IDLE: begin
          pulse_cnt <= 5'h00;
          if (start_req) begin
            trig_state <= prom_loader_pkg::TRIG_SAMPLE;
          end else if (trig_rise) begin
            rev_captured <= rev_now;
          end
        end
        prom_loader_pkg::TRIG_SAMPLE: begin
          rev_captured <= rev_now;
          trig_state <= prom_loader_pkg::TRIG_PULSE;
        end
        prom_loader_pkg::TRIG_PULSE: begin
          pulse_cnt <= pulse_cnt + 5'h01;
          if (pulse_cnt == 5'(`PULSE_CYCLES - 1)) begin
            trig_state <= prom_loader_pkg::TRIG_IDLE;
          end
        end
        default: begin
          trig_state <= prom_loader_pkg::TRIG_IDLE;
        end
      endcase
    end
  end

  // Pin drive; the revision variant releases the line so outside pulses are seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_trigger_out <= 1'b1;
      config_trigger_oe <= SERIAL_ONLY;
    end else begin
      config_trigger_out <= trig_state != prom_loader_pkg::TRIG_PULSE;
      config_trigger_oe <= SERIAL_ONLY || trig_state == prom_loader_pkg::TRIG_PULSE;
    end
  end

  // Address counter and cascade hand-over
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr <= 8'h00;
      bit_idx <= 3'h0;
      done <= 1'b0;
    end else if (!active || trig_rise) begin
      addr <= bank_start;
      bit_idx <= 3'h0;
      done <= 1'b0;
    end else if (clk_rise && !done && !hold) begin
      bit_idx <= ctrl.byte_wide ? 3'h0 : bit_idx + 3'h1;
      if (byte_last) begin
        if (addr == bank_end) begin
          done <= 1'b1;
        end else begin
          addr <= addr + 8'h01;
        end
      end
    end
  end

  // Outputs all registered; data follows the address one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
      chain_enable_out_n <= 1'b1;
      forwarded_clock <= 1'b0;
      forwarded_clock_oe <= 1'b0;
    end else begin
      data_out <= ctrl.byte_wide ? mem[addr] : {7'h00, mem[addr][3'(`LAST_BIT - bit_idx)]};
      data_oe <= active && !done;
      chain_enable_out_n <= !(active && done && bank_end == `TERMINAL_COUNT);
      forwarded_clock <= pins.config_clock;
      forwarded_clock_oe <= active && !done && !SERIAL_ONLY;
    end
  end

  // Helper: length of the driven low time
  logic [4:0] low_len;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_len <= 5'h00;
    end else if (config_trigger_oe && !config_trigger_out) begin
      low_len <= low_len + 5'h01;
    end else begin
      low_len <= 5'h00;
    end
  end

  pulse_width_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(config_trigger_out) |-> low_len == 5'(`PULSE_CYCLES))
    else $error("trigger pulse length wrong");

  sample_first_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(config_trigger_out) |-> $past(trig_state, 2) == prom_loader_pkg::TRIG_SAMPLE)
    else $error("trigger pulse not preceded by revision sample");

  rev_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
    trig_state == prom_loader_pkg::TRIG_SAMPLE |=> rev_captured == $past(rev_now))
    else $error("revision not captured");

  disabled_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    !active ##1 !active |-> chain_enable_out_n && !data_oe && addr == bank_start)
    else $error("disabled outputs wrong");

  enable_data_a: assert property (@(posedge pclk) disable iff (!presetn)
    active && !done |=> data_oe)
    else $error("data not enabled");

  terminal_chain_a: assert property (@(posedge pclk) disable iff (!presetn)
    active && done && bank_end == `TERMINAL_COUNT |=> !chain_enable_out_n && !data_oe)
    else $error("terminal count hand-over wrong");

  busy_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    active && hold && !trig_rise |=> $stable(addr) && $stable(bit_idx))
    else $error("address moved while busy");

  advance_a: assert property (@(posedge pclk) disable iff (!presetn)
    active && !trig_rise && clk_rise && !done && !hold && byte_last && addr != bank_end
    |=> addr == $past(addr) + 8'h01)
    else $error("address did not advance");

  once_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(config_trigger_out) |-> ##1 config_trigger_out [*2])
    else $error("trigger pulsed twice back to back");

endmodule
`default_nettype wire

// ### verification/target_port.sv
// Behavioural model of the target's configuration port
`timescale 1ns/1ps
`default_nettype none
module target_port (
  // Control from bench
  input wire logic run,
  input wire logic stall,
  // Port pins
  input wire logic [7:0] data_in,
  output logic config_clock,
  output logic busy,
  // Observation
  output logic [7:0] captured,
  output int edges
);
  // Free-running oscillator, parked low between frames
  initial begin
    config_clock = 1'b0;
    #7;
    forever begin
      #100;
      config_clock = run ? ~config_clock : 1'b0;
    end
  end
  // Target select strapped low for byte transfers
  logic select_n;
  assign select_n = 1'b0;
  initial edges = 0;
  initial captured = 8'h00;
  always @(posedge config_clock) begin
    if (!select_n) begin
      captured <= data_in;
    end
    edges <= edges + 1;
  end
  assign busy = stall;
endmodule
`default_nettype wire

// ### verification/prom_loader_tb.sv
// Self-checking bench for the configuration memory readout
`timescale 1ns/1ps
`default_nettype none
`include "prom_loader_defs.svh"
module prom_loader_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, ce_n, oe_reset_n;
  logic [7:0] paddr, data_out, captured;
  logic [31:0] pwdata, prdata;
  logic data_oe, chain_enable_out_n, trig_out, trig_oe, ext_en, ext_low, run, stall, config_clock;
  logic [1:0] rev_pins;
  logic fwd_clk, fwd_oe;
  wire trig_line;
  int err_count, tests_run, edges, cycles;

  // Pull-up keeps the released line high
  assign trig_line = trig_oe ? trig_out : (ext_low ? 1'b0 : 1'b1);
  prom_loader u_prom_loader (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .config_clock(config_clock), .busy(busy), .data_out(data_out),
    .data_oe(data_oe), .forwarded_clock(fwd_clk), .forwarded_clock_oe(fwd_oe), .ce_n(ce_n),
    .oe_reset_n(oe_reset_n), .chain_enable_out_n(chain_enable_out_n),
    .config_trigger_in(trig_line), .config_trigger_out(trig_out), .config_trigger_oe(trig_oe),
    .external_revision_enable(ext_en), .revision_select_pins(rev_pins));
  target_port u_target_port (.run(run), .stall(stall), .data_in(data_out),
    .config_clock(config_clock), .busy(busy), .captured(captured), .edges(edges));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic complete_run;
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      complete_run;
    end
  end

  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge so a following call never re-raises psel in this step
    @(posedge pclk);
  endtask

  // Run the link clock until the partner has seen n rising edges in total
  task automatic clk_to(input int n);
    int k;
    k = 0;
    run <= 1'b1;
    while (edges < n && k < 4000) begin
      @(posedge pclk);
      k++;
    end
    run <= 1'b0;
    cyc(12);
  endtask

  task automatic t_regs;
    logic [31:0] q;
    logic e;
    apb(1'b1, `LOAD_ADDR_OFFSET, 32'h0000_0000, q, e);
    apb(1'b1, `LOAD_DATA_OFFSET, 32'h0000_00A5, q, e);
    apb(1'b1, `LOAD_DATA_OFFSET, 32'h0000_003C, q, e);
    apb(1'b1, `LOAD_DATA_OFFSET, 32'h0000_0096, q, e);
    apb(1'b1, `LOAD_ADDR_OFFSET, 32'h0000_0000, q, e);
    apb(1'b0, `LOAD_DATA_OFFSET, 32'h0000_0000, q, e);
    chk(q === 32'h0000_00A5 && e === 1'b0, "memory readback");
    apb(1'b0, 8'h10, 32'h0000_0000, q, e);
    chk(e === 1'b1 && q === 32'h0000_0000, "unmapped access");
    apb(1'b1, `CTRL_OFFSET, 32'h0000_0008, q, e);
  endtask

  task automatic t_stream;
    ce_n <= 1'b0;
    cyc(8);
    chk(data_oe === 1'b1 && data_out === 8'hA5, "first byte on enable");
    chk(fwd_oe === 1'b1, "forwarded clock driven while streaming");
    clk_to(2);
    chk(captured === 8'h3C && data_out === 8'h96, "byte advance");
    stall <= 1'b1;
    cyc(4);
    clk_to(3);
    chk(captured === 8'h96 && data_out === 8'h96, "busy hold");
    stall <= 1'b0;
    clk_to(3 + `TERMINAL_COUNT - 2);
    chk(chain_enable_out_n === 1'b1 && data_oe === 1'b1, "early hand-over");
    clk_to(4 + `TERMINAL_COUNT - 2);
    chk(chain_enable_out_n === 1'b0 && data_oe === 1'b0, "hand-over at end");
    chk(fwd_oe === 1'b0 && fwd_clk === 1'b0, "forwarded clock released at end");
    clk_to(5 + `TERMINAL_COUNT - 2);
    chk(chain_enable_out_n === 1'b0 && data_oe === 1'b0, "counter past end");
    ce_n <= 1'b1;
    cyc(6);
    chk(chain_enable_out_n === 1'b1 && data_oe === 1'b0, "disabled outputs");
    ce_n <= 1'b0;
    cyc(6);
    chk(data_oe === 1'b1 && data_out === 8'hA5, "address reset by enable");
    oe_reset_n <= 1'b0;
    cyc(6);
    chk(chain_enable_out_n === 1'b1 && data_oe === 1'b0, "held in reset");
    oe_reset_n <= 1'b1;
    cyc(4);
  endtask

  task automatic t_trigger;
    int k;
    int w;
    int x;
    logic [31:0] q;
    logic e;
    k = 0;
    w = 0;
    x = 0;
    apb(1'b1, `CTRL_OFFSET, 32'h0000_0025, q, e);
    while (trig_out !== 1'b0 && w < 20) begin
      @(posedge pclk);
      w++;
    end
    while (trig_out === 1'b0 && k < 40) begin
      @(posedge pclk);
      k++;
      x += (trig_out === 1'b0 && trig_oe !== 1'b1) ? 1 : 0;
    end
    chk(k * 25 >= 300 && k * 25 <= 500 && k === `PULSE_CYCLES && x === 0, "pulse width");
    x = 0;
    repeat (40) begin
      @(posedge pclk);
      x += (trig_out === 1'b1) ? 0 : 1;
    end
    chk(x === 0 && trig_oe === 1'b0, "single pulse, line released");
    apb(1'b0, `STATUS_OFFSET, 32'h0000_0000, q, e);
    chk(q[9:8] === 2'h2 && q[11] === 1'b0, "command revision captured");
    ext_en <= 1'b1;
    rev_pins <= 2'h3;
    ext_low <= 1'b1;
    cyc(16);
    ext_low <= 1'b0;
    cyc(6);
    apb(1'b0, `STATUS_OFFSET, 32'h0000_0000, q, e);
    chk(q[9:8] === 2'h3, "external edge revision captured");
  endtask

  initial begin
    err_count = 0;
    tests_run = 0;
    cycles = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    ce_n = 1'b1;
    oe_reset_n = 1'b1;
    ext_en = 1'b0;
    ext_low = 1'b0;
    rev_pins = 2'h0;
    run = 1'b0;
    stall = 1'b0;
    cyc(10);
    chk(chain_enable_out_n === 1'b1 && data_oe === 1'b0 && trig_out === 1'b1, "reset state");
    presetn <= 1'b1;
    cyc(2);
    t_regs();
    t_stream();
    t_trigger();
    complete_run;
  end
endmodule
`default_nettype wire
